// ---- acs_pkg.sv ----
// Purpose: Shared constants and types for the converter configuration block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Register offsets here are byte addresses
package acs_pkg;

   localparam int unsigned ACS_AW = 5;

   // Register byte offsets
   localparam logic [ACS_AW-1:0] ACS_OFF_CLK_CFG  = 5'h00;
   localparam logic [ACS_AW-1:0] ACS_OFF_CH_SEL   = 5'h04;
   localparam logic [ACS_AW-1:0] ACS_OFF_BG_EN    = 5'h08;
   localparam logic [ACS_AW-1:0] ACS_OFF_SCAN_LO  = 5'h0C;
   localparam logic [ACS_AW-1:0] ACS_OFF_SCAN_HI  = 5'h10;
   localparam logic [ACS_AW-1:0] ACS_OFF_SEQ_CTRL = 5'h14;
   localparam logic [ACS_AW-1:0] ACS_OFF_STATUS   = 5'h18;

   // Implemented-bit masks (also the write masks)
   localparam logic [15:0] ACS_MASK_CLK_CFG  = 16'h9FFF;
   localparam logic [15:0] ACS_MASK_CH_SEL   = 16'h9F9F;
   localparam logic [15:0] ACS_MASK_BG_EN    = 16'h0007;
   localparam logic [15:0] ACS_MASK_SCAN_LO  = 16'hFFFF;
   localparam logic [15:0] ACS_MASK_SCAN_HI  = 16'h0FFF;
   localparam logic [15:0] ACS_MASK_SEQ_CTRL = 16'h0401;

   localparam logic [15:0] ACS_RST_VAL       = 16'h0000;

   // Field positions
   localparam int unsigned ACS_BIT_CLK_SRC   = 15;
   localparam int unsigned ACS_SAMC_LSB      = 8;
   localparam int unsigned ACS_NEG_B_BIT     = 15;
   localparam int unsigned ACS_POS_B_LSB     = 8;
   localparam int unsigned ACS_NEG_A_BIT     = 7;
   localparam int unsigned ACS_POS_A_LSB     = 0;
   localparam int unsigned ACS_BIT_SCAN_EN   = 10;
   localparam int unsigned ACS_BIT_ALT_EN    = 0;

   // Input codes
   localparam logic [4:0]  ACS_CODE_LAST_PIN = 5'h17;
   localparam logic [4:0]  ACS_CODE_LO_HOLE  = 5'h1C;
   localparam logic [4:0]  ACS_CODE_HI_HOLE  = 5'h1E;
   localparam logic [4:0]  ACS_CODE_FIRST_HI = 5'h10;
   localparam int unsigned ACS_NUM_CH        = 28;

   typedef struct packed {
      logic [4:0] pos_code;
      logic       neg_alt_pin;
      logic       pos_usable;
   } acs_mux_sel_t;

   typedef struct packed {
      logic       sample_strobe;
      logic       seq_restart;
      logic       conv_done;
   } acs_seq_evt_t;

endpackage : acs_pkg

// ---- acs_samp_timer.sv ----
// Purpose: Auto-sample duration counter in conversion clock periods
// Assumes: tad_en is a one-cycle enable
// Notes:   Zero periods ends sampling on the next cycle
`timescale 1ns/1ps
module acs_samp_timer #(
   parameter int unsigned SAMC_W = 5
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // Control
   input  wire logic              start,
   input  wire logic              tad_en,
   input  wire logic [SAMC_W-1:0] auto_sample_periods,
   // Status
   output logic                   busy,
   output logic                   done
);
   import acs_pkg::*;

   typedef struct packed {
      logic [SAMC_W-1:0] cnt;
      logic              busy;
      logic              done;
   } acs_smp_st_t;

   acs_smp_st_t st_ff;
   acs_smp_st_t nxt_st;

   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.done = 1'b0;
      if (start)
      begin
         nxt_st.busy = 1'b1;
         nxt_st.cnt  = '0;
      end
      else if (st_ff.busy && (st_ff.cnt >= auto_sample_periods))
      begin
         nxt_st.busy = 1'b0;
         nxt_st.done = 1'b1;
      end
      else if (st_ff.busy && tad_en)
      begin
         nxt_st.cnt = st_ff.cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign busy = st_ff.busy;
   assign done = st_ff.done;

endmodule : acs_samp_timer

// ---- acs_tad_div.sv ----
// Purpose: Conversion clock period enable from system clock or RC source
// Assumes: RC source tick is already synchronised to pclk
// Notes:   Emits one-cycle enable per conversion clock period
`timescale 1ns/1ps
module acs_tad_div #(
   parameter int unsigned DIV_W = 8
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Control
   input  wire logic             conv_clock_source_sel,
   input  wire logic [DIV_W-1:0] conv_clock_divider,
   input  wire logic             rc_tick,
   // Output
   output logic                  tad_en
);
   import acs_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tad;
   } acs_div_st_t;

   acs_div_st_t st_ff;
   acs_div_st_t nxt_st;

   always_comb
   begin
      nxt_st     = st_ff;
      nxt_st.tad = 1'b0;
      if (conv_clock_source_sel)
      begin
         nxt_st.cnt = '0;
         nxt_st.tad = rc_tick;
      end
      else if (st_ff.cnt >= conv_clock_divider)
      begin
         // Period is divider plus one cycles
         nxt_st.cnt = '0;
         nxt_st.tad = 1'b1;
      end
      else
      begin
         nxt_st.cnt = st_ff.cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign tad_en = st_ff.tad;

endmodule : acs_tad_div

// ---- acs_top.sv ----
// Purpose: Converter clock, sample time, input mux and scan configuration
// Assumes: APB slave on pclk; RC clock tick arrives asynchronously
// Notes:   Analog converter and result buffer lie outside this block
//
// Notes on behaviour
// - Clock source bit set selects RC clock, clear selects system clock divider
// - Auto-sample time counts zero to 31 conversion clock periods
// - Conversion clock period is divider field plus one cycles
// - Divider assumes instruction cycle of two oscillator periods, no doze or PLL
// - Clock register bits 14 and 13 are reserved, kept zero
// - On small packages codes for pins 16 to 23 select nothing usable
// - Sixth band gap input enabled only while bit 2 set
// - Half band gap input enabled only while bit 1 set
// - Full band gap input enabled only while bit 0 set
// - Reference enable bits 15 to 3 read zero, ignore writes
// - Low scan mask bits include channels 0 to 15 in scan
// - High scan mask covers channels 16 to 27 including internal sources
// - Scan applies to first setting positive input only when scan enabled
// - Alternate mode uses first setting, then alternates second and first
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module acs_top #(
   parameter bit          SMALL_PACKAGE = 1'b0,
   parameter int unsigned NUM_CH        = acs_pkg::ACS_NUM_CH
) (
   // Clock and reset
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // APB slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [31:0]                paddr,
   input  wire logic [31:0]                pwdata,
   input  wire logic [3:0]                 pstrb,
   output logic                            pready,
   output logic [31:0]                     prdata,
   output logic                            pslverr,
   // Converter sequencing
   input  wire logic                       rc_clock_tick,
   input  wire logic                       sample_start,
   input  wire logic                       seq_restart,
   output logic                            tad_en,
   output logic                            sampling,
   output logic                            sample_done,
   // Analog mux controls
   output logic [acs_pkg::ACS_POS_A_LSB+4:0] ch0_pos_code,
   output logic                            ch0_pos_usable,
   output logic                            ch0_neg_alt_pin,
   output logic                            using_second_setting,
   output logic [2:0]                      bandgap_enables
);
   import acs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [15:0]      clk_cfg;
      logic [15:0]      ch_sel;
      logic [15:0]      bg_en;
      logic [15:0]      scan_lo;
      logic [15:0]      scan_hi;
      logic [15:0]      seq_ctrl;
      logic [31:0]      rdata;
      logic             alt_phase;
      logic [4:0]       scan_idx;
      logic [4:0]       pos_code;
      logic             pos_usable;
      logic             neg_alt;
      logic             use_b;
      logic             rc_meta;
      logic             rc_sync;
      logic             rc_prev;
   } acs_top_st_t;

   acs_top_st_t st_ff;
   acs_top_st_t nxt_st;

   logic tad_w;
   logic smp_busy;
   logic smp_done;

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   // Merge written bytes under the implemented-bit mask
   function automatic logic [15:0] wr_merge(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb,
                                            input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (strb[0])
         v[7:0] = wd[7:0];
      if (strb[1])
         v[15:8] = wd[15:8];
      return v & mask;
   endfunction : wr_merge

   // Whether a positive input code reaches a usable source
   function automatic logic code_usable(input logic [4:0] code);
      logic ok;
      ok = 1'b1;
      if ((code >= ACS_CODE_LO_HOLE) && (code <= ACS_CODE_HI_HOLE))
         ok = 1'b0;
      else if (SMALL_PACKAGE && (code >= ACS_CODE_FIRST_HI)
               && (code <= ACS_CODE_LAST_PIN))
         ok = 1'b0;
      return ok;
   endfunction : code_usable

   // Next enabled scan channel after the current one, wrapping
   function automatic logic [4:0] next_scan(input logic [4:0]        cur,
                                            input logic [NUM_CH-1:0] msk);
      logic [4:0] r;
      logic       hit;
      r   = cur;
      hit = 1'b0;
      for (int i = 1; i <= NUM_CH; i++)
      begin
         if (!hit && msk[(int'(cur) + i) % NUM_CH])
         begin
            r   = 5'((int'(cur) + i) % NUM_CH);
            hit = 1'b1;
         end
      end
      return r;
   endfunction : next_scan

   // First enabled scan channel
   function automatic logic [4:0] first_scan(input logic [NUM_CH-1:0] msk);
      logic [4:0] r;
      logic       hit;
      r   = '0;
      hit = 1'b0;
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (!hit && msk[i])
         begin
            r   = 5'(i);
            hit = 1'b1;
         end
      end
      return r;
   endfunction : first_scan

   // Scan index to positive input code, unchanged for every channel, pins and internal sources alike
   function automatic logic [4:0] scan_code(input logic [4:0] idx);
      return idx;
   endfunction : scan_code

   ////////////////////////////////////////////////////////////////////////////
   // Register and sequencing logic

   logic [ACS_AW-1:0]  addr;
   logic               wr_acc;
   logic               rd_setup;
   logic [NUM_CH-1:0]  scan_mask;
   logic               scan_on;
   logic               alt_on;
   logic [4:0]         pick_code;
   logic               pick_neg;

   assign addr      = paddr[ACS_AW-1:0];
   assign wr_acc    = psel && penable && pwrite;
   assign rd_setup  = psel && !penable && !pwrite;
   // Channels 0-15 from the low mask, 16-27 from the high mask
   assign scan_mask = {st_ff.scan_hi[NUM_CH-17:0], st_ff.scan_lo};
   assign scan_on   = st_ff.seq_ctrl[ACS_BIT_SCAN_EN];
   assign alt_on    = st_ff.seq_ctrl[ACS_BIT_ALT_EN];

   always_comb
   begin
      nxt_st   = st_ff;
      pick_code = '0;
      pick_neg  = 1'b0;

      // Async RC tick passes two flops before the edge detect
      nxt_st.rc_meta = rc_clock_tick;
      nxt_st.rc_sync = st_ff.rc_meta;
      nxt_st.rc_prev = st_ff.rc_sync;

      // Writes on the access phase, masked so reserved bits stay zero
      if (wr_acc)
      begin
         unique case (addr)
            ACS_OFF_CLK_CFG:
               nxt_st.clk_cfg = wr_merge(st_ff.clk_cfg, pwdata, pstrb,
                                         ACS_MASK_CLK_CFG);
            ACS_OFF_CH_SEL:
               nxt_st.ch_sel = wr_merge(st_ff.ch_sel, pwdata, pstrb,
                                        ACS_MASK_CH_SEL);
            ACS_OFF_BG_EN:
               nxt_st.bg_en = wr_merge(st_ff.bg_en, pwdata, pstrb,
                                       ACS_MASK_BG_EN);
            ACS_OFF_SCAN_LO:
               nxt_st.scan_lo = wr_merge(st_ff.scan_lo, pwdata, pstrb,
                                         ACS_MASK_SCAN_LO);
            ACS_OFF_SCAN_HI:
               nxt_st.scan_hi = wr_merge(st_ff.scan_hi, pwdata, pstrb,
                                         ACS_MASK_SCAN_HI);
            ACS_OFF_SEQ_CTRL:
               nxt_st.seq_ctrl = wr_merge(st_ff.seq_ctrl, pwdata, pstrb,
                                          ACS_MASK_SEQ_CTRL);
            default:
               nxt_st.rdata = st_ff.rdata;
         endcase
      end

      // Read data captured in setup so prdata comes from a flop
      if (rd_setup)
      begin
         unique case (addr)
            ACS_OFF_CLK_CFG:  nxt_st.rdata = {16'h0000, st_ff.clk_cfg};
            ACS_OFF_CH_SEL:   nxt_st.rdata = {16'h0000, st_ff.ch_sel};
            ACS_OFF_BG_EN:    nxt_st.rdata = {16'h0000, st_ff.bg_en};
            ACS_OFF_SCAN_LO:  nxt_st.rdata = {16'h0000, st_ff.scan_lo};
            ACS_OFF_SCAN_HI:  nxt_st.rdata = {16'h0000, st_ff.scan_hi};
            ACS_OFF_SEQ_CTRL: nxt_st.rdata = {16'h0000, st_ff.seq_ctrl};
            ACS_OFF_STATUS:   nxt_st.rdata = {16'h0000, 3'h0, st_ff.scan_idx,
                                              6'h00, st_ff.use_b, st_ff.alt_phase};
            default:          nxt_st.rdata = 32'h0000_0000;
         endcase
      end

      // Sample sequencing: alternate phase and scan pointer
      if (seq_restart)
      begin
         nxt_st.alt_phase = 1'b0;
         nxt_st.scan_idx  = first_scan(scan_mask);
      end
      else if (smp_done)
      begin
         // First sample uses the first setting, then toggle
         nxt_st.alt_phase = alt_on ? !st_ff.alt_phase : 1'b0;
         if (scan_on && (!alt_on || st_ff.alt_phase == 1'b0))
            nxt_st.scan_idx = next_scan(st_ff.scan_idx, scan_mask);
      end

      // Setting selection for the upcoming sample
      nxt_st.use_b = alt_on && nxt_st.alt_phase;
      if (nxt_st.use_b)
      begin
         // Same encoding as the first setting
         pick_code = nxt_st.ch_sel[ACS_POS_B_LSB +: 5];
         pick_neg  = nxt_st.ch_sel[ACS_NEG_B_BIT];
      end
      else
      begin
         pick_code = scan_on ? scan_code(nxt_st.scan_idx)
                             : nxt_st.ch_sel[ACS_POS_A_LSB +: 5];
         pick_neg  = nxt_st.ch_sel[ACS_NEG_A_BIT];
      end
      nxt_st.pos_code   = pick_code;
      nxt_st.pos_usable = code_usable(pick_code);
      nxt_st.neg_alt    = pick_neg;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Submodules

   // Divider runs in pclk cycles; a pclk cycle stands for one instruction cycle
   acs_tad_div #(
      .DIV_W                 (8)
   ) u_div (
      .pclk                  (pclk),
      .presetn               (presetn),
      .conv_clock_source_sel (st_ff.clk_cfg[ACS_BIT_CLK_SRC]),
      .conv_clock_divider    (st_ff.clk_cfg[7:0]),
      .rc_tick               (st_ff.rc_sync && !st_ff.rc_prev),
      .tad_en                (tad_w)
   );

   acs_samp_timer #(
      .SAMC_W                (5)
   ) u_smp (
      .pclk                  (pclk),
      .presetn               (presetn),
      .start                 (sample_start),
      .tad_en                (tad_w),
      .auto_sample_periods   (st_ff.clk_cfg[ACS_SAMC_LSB +: 5]),
      .busy                  (smp_busy),
      .done                  (smp_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign pready               = 1'b1;
   assign pslverr              = 1'b0;
   assign prdata               = st_ff.rdata;
   assign tad_en               = tad_w;
   assign sampling             = smp_busy;
   assign sample_done          = smp_done;
   assign ch0_pos_code         = st_ff.pos_code;
   assign ch0_pos_usable       = st_ff.pos_usable;
   assign ch0_neg_alt_pin      = st_ff.neg_alt;
   assign using_second_setting = st_ff.use_b;
   assign bandgap_enables      = st_ff.bg_en[2:0];

endmodule : acs_top

// ---- acs_top_assertions.sv ----
// Purpose: Port-level checks for the converter configuration block
// Assumes: Shadows of written fields follow APB writes at the same edge
// Notes:   Mux checks skip scan mode, where the code comes from the mask
`timescale 1ns/1ps
module acs_top_chk
   import acs_pkg::*;
#(
   parameter bit SMALL_PACKAGE = 1'b0
) (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   // Sequencing
   input wire logic        rc_clock_tick,
   input wire logic        sample_start,
   input wire logic        seq_restart,
   input wire logic        tad_en,
   input wire logic        sampling,
   input wire logic        sample_done,
   // Mux controls
   input wire logic [4:0]  ch0_pos_code,
   input wire logic        ch0_pos_usable,
   input wire logic        ch0_neg_alt_pin,
   input wire logic        using_second_setting,
   input wire logic [2:0]  bandgap_enables
);
   logic        wr;
   logic [15:0] clk_ff, ch_ff, seq_ff;
   logic [1:0]  tads_ff;
   logic [8:0]  gap_ff;

   function automatic logic [15:0] mrg(input logic [15:0] old);
      mrg = {pstrb[1] ? pwdata[15:8] : old[15:8], pstrb[0] ? pwdata[7:0] : old[7:0]};
   endfunction : mrg

   assign wr = psel && penable && pwrite;

   ////////////////////////////////////////////////////////////////////////////////
   // Period is judged only after three pulses, so a write mid-count is not blamed
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clk_ff  <= '0;
         ch_ff   <= '0;
         seq_ff  <= '0;
         tads_ff <= '0;
         gap_ff  <= '0;
      end
      else
      begin
         if (wr && paddr == 32'(ACS_OFF_CLK_CFG))
            clk_ff <= mrg(clk_ff);
         if (wr && paddr == 32'(ACS_OFF_CH_SEL))
            ch_ff <= mrg(ch_ff);
         if (wr && paddr == 32'(ACS_OFF_SEQ_CTRL))
            seq_ff <= mrg(seq_ff);
         if (wr && paddr == 32'(ACS_OFF_CLK_CFG))
            tads_ff <= '0;
         else if (tad_en && tads_ff != 2'd3)
            tads_ff <= tads_ff + 2'd1;
         if (tad_en)
            gap_ff <= 9'd1;
         else if (gap_ff != 9'h1FF)
            gap_ff <= gap_ff + 9'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   div_period_a: assert property (@(posedge pclk) disable iff (!presetn)
      tad_en && !clk_ff[15] && tads_ff == 2'd3 |-> gap_ff == {1'b0, clk_ff[7:0]} + 9'd1)
      else $error("conversion clock period wrong");
   rc_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_ff[15] && !rc_clock_tick)[*6] |-> !tad_en)
      else $error("tad pulse without rc edge");
   samp_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_start |=> sampling)
      else $error("sampling did not start");
   done_ends_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_done |-> !sampling && $past(sampling))
      else $error("done without end of sampling");
   bg_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == 32'(ACS_OFF_BG_EN) && pstrb[0] |=> bandgap_enables == $past(pwdata[2:0]))
      else $error("band gap enables wrong");
   code_hole_a: assert property (@(posedge pclk) disable iff (!presetn)
      ch0_pos_code >= ACS_CODE_LO_HOLE && ch0_pos_code <= ACS_CODE_HI_HOLE |-> !ch0_pos_usable)
      else $error("unimplemented code marked usable");
   pin_usable_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_done ##1 (ch0_pos_code <= ACS_CODE_LAST_PIN)
      |-> ch0_pos_usable == !(SMALL_PACKAGE && ch0_pos_code >= ACS_CODE_FIRST_HI))
      else $error("pin usability wrong");
   mux_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_done && !seq_ff[10] |=>
      ch0_pos_code == (using_second_setting ? ch_ff[12:8] : ch_ff[4:0]) &&
      ch0_neg_alt_pin == (using_second_setting ? ch_ff[15] : ch_ff[7]))
      else $error("mux fields wrong");
   alt_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_done && seq_ff[0] && !seq_restart |=> using_second_setting != $past(using_second_setting))
      else $error("alternate setting did not toggle");
   alt_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_done && !seq_ff[0] |=> !using_second_setting)
      else $error("second setting used without alternate");
endmodule : acs_top_chk

// ---- acs_top_tb.sv ----
// Purpose: Self-checking bench for the converter configuration block
// Assumes: Zero-wait APB slave on pclk
// Notes:   Sample times measured with divider 0, one tad per cycle
`timescale 1ns/1ps
module acs_top_tb;
   import acs_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, rd, obs;
   logic [3:0]  pstrb;
   logic        rc_clock_tick, sample_start, seq_restart, tad_en, sampling, sample_done;
   logic        ch0_pos_usable, ch0_neg_alt_pin, using_second_setting;
   logic [4:0]  ch0_pos_code;
   logic [2:0]  bandgap_enables;
   int          error_cnt, total_checks, cyc, tads, t0, i, d, d0, g;
   logic [31:0] offs [6] = '{32'(ACS_OFF_CLK_CFG), 32'(ACS_OFF_CH_SEL), 32'(ACS_OFF_BG_EN),
                             32'(ACS_OFF_SCAN_LO), 32'(ACS_OFF_SCAN_HI), 32'(ACS_OFF_SEQ_CTRL)};
   logic [15:0] msk [6]  = '{ACS_MASK_CLK_CFG, ACS_MASK_CH_SEL, ACS_MASK_BG_EN,
                             ACS_MASK_SCAN_LO, ACS_MASK_SCAN_HI, ACS_MASK_SEQ_CTRL};
   logic [7:0]  dv [3]   = '{8'h00, 8'h03, 8'hFF};
   logic [4:0]  ring [3] = '{5'h05, 5'h1B, 5'h02};
   int          sv [3]   = '{1, 5, 31};

   acs_top dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .rc_clock_tick(rc_clock_tick), .sample_start(sample_start),
      .seq_restart(seq_restart), .tad_en(tad_en), .sampling(sampling),
      .sample_done(sample_done), .ch0_pos_code(ch0_pos_code),
      .ch0_pos_usable(ch0_pos_usable), .ch0_neg_alt_pin(ch0_neg_alt_pin),
      .using_second_setting(using_second_setting), .bandgap_enables(bandgap_enables));

   assign obs = {24'h0, using_second_setting, ch0_neg_alt_pin, ch0_pos_usable, ch0_pos_code};

   always #2.5 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////////
   // Counted off the falling edge so design flops are settled when read
   always @(negedge pclk)
   begin
      cyc <= cyc + 1;
      if (tad_en === 1'b1)
         tads <= tads + 1;
      if (cyc == 10000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Holds the request until pready is seen high, then one idle edge
   task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] dt,
                      input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      chk({31'h0, pslverr}, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic smp(output int n);
      sample_start <= 1'b1;
      @(posedge pclk);
      sample_start <= 1'b0;
      n = 0;
      do
      begin
         @(negedge pclk);
         n++;
      end
      while (sample_done !== 1'b1);
      repeat (2) @(posedge pclk);
   endtask : smp

   task automatic restart;
      seq_restart <= 1'b1;
      @(posedge pclk);
      seq_restart <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : restart

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      rc_clock_tick = 1'b0;
      sample_start = 1'b0;
      seq_restart = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 6; i++)
      begin
         apb(offs[i], 1'b0, 32'h0, 4'hF);
         chk(rd, 32'h0);
         apb(offs[i], 1'b1, 32'hFFFF_FFFF, 4'hF);
         apb(offs[i], 1'b0, 32'h0, 4'hF);
         chk(rd, {16'h0, msk[i]});
      end
      apb(32'h1C, 1'b1, 32'hFFFF_FFFF, 4'hF);
      apb(32'h1C, 1'b0, 32'h0, 4'hF);
      chk(rd, 32'h0);
      apb(offs[3], 1'b1, 32'h0, 4'h1);
      apb(offs[3], 1'b0, 32'h0, 4'hF);
      chk(rd, 32'h0000_FF00);
      $display("register test done");
      for (i = 0; i < 3; i++)
      begin
         apb(offs[2], 1'b1, 32'(1 << i), 4'hF);
         chk({29'h0, bandgap_enables}, 32'(1 << i));
      end
      apb(offs[5], 1'b1, 32'h0, 4'hF);
      $display("band gap test done");
      // Third gap after the write, clear of any count in flight
      for (i = 0; i < 3; i++)
      begin
         apb(offs[0], 1'b1, {24'h0, dv[i]}, 4'hF);
         t0 = tads;
         while (tads < t0 + 3)
            @(posedge pclk);
         g = cyc;
         while (tads < t0 + 4)
            @(posedge pclk);
         chk(32'(cyc - g), {24'h0, dv[i]} + 32'd1);
      end
      apb(offs[0], 1'b1, 32'h8000, 4'hF);
      repeat (10) @(posedge pclk);
      t0 = tads;
      repeat (20) @(posedge pclk);
      chk(32'(tads - t0), 32'd0);
      repeat (3)
      begin
         rc_clock_tick <= 1'b1;
         repeat (4) @(posedge pclk);
         rc_clock_tick <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      repeat (8) @(posedge pclk);
      chk(32'(tads - t0), 32'd3);
      $display("clock test done");
      apb(offs[0], 1'b1, 32'h0, 4'hF);
      smp(d0);
      for (i = 0; i < 3; i++)
      begin
         apb(offs[0], 1'b1, 32'(sv[i]) << 8, 4'hF);
         smp(d);
         chk(32'(d - d0), 32'(sv[i]));
      end
      $display("sample time test done");
      apb(offs[0], 1'b1, 32'h0100, 4'hF);
      apb(offs[1], 1'b1, 32'h8517, 4'hF);
      apb(offs[5], 1'b1, 32'h0001, 4'hF);
      restart();
      for (i = 1; i < 5; i++)
      begin
         smp(d);
         chk(obs, (i % 2) ? 32'hE5 : 32'h37);
      end
      apb(offs[5], 1'b1, 32'h0, 4'hF);
      smp(d);
      chk(obs, 32'h37);
      apb(offs[1], 1'b1, 32'h001C, 4'hF);
      smp(d);
      chk(obs, 32'h1C);
      $display("mux test done");
      apb(offs[5], 1'b1, 32'h0400, 4'hF);
      apb(offs[3], 1'b1, 32'h0024, 4'hF);
      apb(offs[4], 1'b1, 32'h0800, 4'hF);
      restart();
      for (i = 0; i < 4; i++)
      begin
         smp(d);
         chk({27'h0, ch0_pos_code}, {27'h0, ring[i % 3]});
      end
      $display("scan test done");
      report_and_stop();
   end
endmodule : acs_top_tb

bind acs_top acs_top_chk #(.SMALL_PACKAGE(SMALL_PACKAGE)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .rc_clock_tick(rc_clock_tick),
   .sample_start(sample_start), .seq_restart(seq_restart), .tad_en(tad_en),
   .sampling(sampling), .sample_done(sample_done), .ch0_pos_code(ch0_pos_code),
   .ch0_pos_usable(ch0_pos_usable), .ch0_neg_alt_pin(ch0_neg_alt_pin),
   .using_second_setting(using_second_setting), .bandgap_enables(bandgap_enables));
